//--- rtl/sab_cfg.svh
// Timing counts, widths and codes of the converter control block
`ifndef SAB_CFG_SVH
`define SAB_CFG_SVH

`define SAB_CLK_NS        100
`define SAB_W             12
`define SAB_MSB_CODE      12'h800
`define SAB_LSB_BIT       12'h001
`define SAB_SHORT_BIT     12'h010
`define SAB_OE_ALL        12'hFFF
`define SAB_OE_BYTE       12'hFF0
`define SAB_OE_NONE       12'h000

// Bit decision periods per speed grade
`define SAB_BIT_SLOW_NS   1600
`define SAB_BIT_MID_NS    1000
`define SAB_BIT_FAST_NS   600
`define SAB_BIT_SLOW_CYC  (`SAB_BIT_SLOW_NS / `SAB_CLK_NS)
`define SAB_BIT_MID_CYC   (`SAB_BIT_MID_NS / `SAB_CLK_NS)
`define SAB_BIT_FAST_CYC  (`SAB_BIT_FAST_NS / `SAB_CLK_NS)

// Status fall after result valid, least time rounded up
`define SAB_HS_SLOW_NS    500
`define SAB_HS_MID_NS     300
`define SAB_HS_FAST_NS    300
`define SAB_HS_SLOW_CYC   ((`SAB_HS_SLOW_NS + `SAB_CLK_NS - 1) / `SAB_CLK_NS)
`define SAB_HS_MID_CYC    ((`SAB_HS_MID_NS + `SAB_CLK_NS - 1) / `SAB_CLK_NS)
`define SAB_HS_FAST_CYC   ((`SAB_HS_FAST_NS + `SAB_CLK_NS - 1) / `SAB_CLK_NS)

// Conversion time windows
`define SAB_TC12_SLOW_MIN_NS 15000
`define SAB_TC12_SLOW_MAX_NS 25000
`define SAB_TC8_SLOW_MIN_NS  10000
`define SAB_TC8_SLOW_MAX_NS  17000
`define SAB_TC12_MID_MIN_NS  9000
`define SAB_TC12_MID_MAX_NS  15000
`define SAB_TC8_MID_MIN_NS   6000
`define SAB_TC8_MID_MAX_NS   10000
`define SAB_TC12_FAST_MAX_NS 9000
`define SAB_TC8_FAST_MAX_NS  6800

`endif

//--- rtl/sab_pkg.sv
// Types of the converter control block
package sab_pkg;
   typedef enum logic [1:0] {
      SAB_IDLE = 2'b00,
      SAB_CONV = 2'b01,
      SAB_HOLD = 2'b10
   } sab_state_e;

   typedef enum logic [1:0] {
      SAB_SPD_SLOW = 2'b00,
      SAB_SPD_MID  = 2'b01,
      SAB_SPD_FAST = 2'b10
   } sab_speed_e;

   typedef logic [11:0] sab_code_t;
endpackage

//--- rtl/sab_sar_if.sv
// Link between the sequencer and the approximation register
`timescale 1ns/100ps
`default_nettype none
interface sab_sar_if;
   logic                start;
   logic                short_cyc;
   logic                step;
   logic                cmp_above;
   sab_pkg::sab_code_t  trial;
   sab_pkg::sab_code_t  result;
   logic                done;

   modport ctl (output start, short_cyc, step, cmp_above,
                input  trial, result, done);
   modport sar (input  start, short_cyc, step, cmp_above,
                output trial, result, done);
endinterface
`default_nettype wire

//--- rtl/sab_sar.sv
// Successive approximation register, MSB first
`timescale 1ns/100ps
`default_nettype none
`include "sab_cfg.svh"
module sab_sar (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sequencer side
   sab_sar_if.sar   sif
);
   sab_pkg::sab_code_t trial_reg;
   sab_pkg::sab_code_t bit_reg;
   sab_pkg::sab_code_t result_reg;
   sab_pkg::sab_code_t keep;
   logic               active_reg;
   logic               short_reg;
   logic               done_reg;
   logic               last;

   // Drop the trial bit when the input sits below the trial level
   assign keep = sif.cmp_above ? trial_reg : (trial_reg & ~bit_reg);
   assign last = (bit_reg == `SAB_LSB_BIT) ||
                 (short_reg && (bit_reg == `SAB_SHORT_BIT));

   always_ff @(posedge clk) begin
      if (rst) begin
         trial_reg  <= 12'h000;
         bit_reg    <= 12'h000;
         active_reg <= 1'b0;
         short_reg  <= 1'b0;
      end else if (sif.start) begin
         trial_reg  <= `SAB_MSB_CODE;
         bit_reg    <= `SAB_MSB_CODE;
         active_reg <= 1'b1;
         short_reg  <= sif.short_cyc;
      end else if (active_reg && sif.step) begin
         if (last) begin
            trial_reg  <= keep;
            active_reg <= 1'b0;
         end else begin
            trial_reg <= keep | (bit_reg >> 1);
            bit_reg   <= bit_reg >> 1;
         end
      end
   end

   // Result loads only at the final decision, short cycles leave low bits 0
   always_ff @(posedge clk) begin
      if (rst) begin
         result_reg <= 12'h000;
         done_reg   <= 1'b0;
      end else begin
         done_reg <= active_reg && sif.step && last;
         if (active_reg && sif.step && last) begin
            result_reg <= keep;
         end
      end
   end

   assign sif.trial  = trial_reg;
   assign sif.result = result_reg;
   assign sif.done   = done_reg;
endmodule
`default_nettype wire

//--- rtl/sab_adc_ctl.sv
// Bus interface and conversion sequencer of the 12-bit converter
//
// Contract
// - Chip select high: no conversion start and no bus drive.
// - Chip enable low keeps the device inactive on the bus.
// - Status high during a whole conversion, low otherwise.
// - Width select chooses 12-bit or 8-bit byte-wide read layout.
// - Byte address sets conversion length at start, byte at read.
// - Read/convert low starts a conversion, high reads the result.
// - Full conversion 15-25 us slow grade, 9-15 us mid grade.
// - Short conversion 10-17 us slow grade, 6-10 us mid grade.
// - Fast grade: 12-bit within 9 us, 8-bit within 6.8 us.
// - Result valid before status falls; fall 300-1200 or under 850 ns.
// - Left-justified fraction code, bit 11 most significant.
// - Unipolar straight binary, lowest input gives all zeros.
// - Bipolar offset binary major carry at mid code.
// - Top step reaches the all-ones code near full scale.
// - Data lines released whenever no read is running.
`timescale 1ns/100ps
`default_nettype none
`include "sab_cfg.svh"
module sab_adc_ctl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Host bus pins
   input  wire logic        cs_n,
   input  wire logic        ce,
   input  wire logic        read_conv,
   input  wire logic        byte_addr_short_cycle,
   input  wire logic        width_12,
   output logic             conversion_status,
   output logic [11:0]      result_bus_o,
   output logic [11:0]      result_bus_oe,
   // Static speed grade
   input  wire logic [1:0]  speed_sel,
   // Analog die
   input  wire logic        cmp_above,
   output logic [11:0]      dac_code
);
   sab_sar_if sif ();

   sab_pkg::sab_state_e state_reg;
   logic [4:0]  sync1_reg;
   logic [4:0]  sync2_reg;
   logic        ce_d_reg;
   logic        cmp1_reg;
   logic        cmp2_reg;
   logic        cs_n_s;
   logic        ce_s;
   logic        rc_s;
   logic        addr_s;
   logic        w12_s;
   logic        start;
   logic        rd_act;
   logic        short_reg;
   logic [7:0]  div_reg;
   logic [7:0]  hold_reg;
   logic [7:0]  bit_cyc;
   logic [7:0]  hs_cyc;
   logic [11:0] data_next;
   logic [11:0] oe_next;

   function automatic logic [7:0] bit_cycles(input logic [1:0] sel);
      unique case (sel)
         sab_pkg::SAB_SPD_MID:  bit_cycles = 8'(`SAB_BIT_MID_CYC);
         sab_pkg::SAB_SPD_FAST: bit_cycles = 8'(`SAB_BIT_FAST_CYC);
         default:               bit_cycles = 8'(`SAB_BIT_SLOW_CYC);
      endcase
   endfunction

   function automatic logic [7:0] hs_cycles(input logic [1:0] sel);
      unique case (sel)
         sab_pkg::SAB_SPD_MID:  hs_cycles = 8'(`SAB_HS_MID_CYC);
         sab_pkg::SAB_SPD_FAST: hs_cycles = 8'(`SAB_HS_FAST_CYC);
         default:               hs_cycles = 8'(`SAB_HS_SLOW_CYC);
      endcase
   endfunction

   sab_sar u_sar (
      .clk (clk),
      .rst (rst),
      .sif (sif)
   );

   // Pins come from the host bus, not from this clock
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_reg <= 5'h01;
         sync2_reg <= 5'h01;
         ce_d_reg  <= 1'b0;
      end else begin
         sync1_reg <= {width_12, byte_addr_short_cycle, read_conv, ce, cs_n};
         sync2_reg <= sync1_reg;
         ce_d_reg  <= sync2_reg[1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp1_reg <= 1'b0;
         cmp2_reg <= 1'b0;
      end else begin
         cmp1_reg <= cmp_above;
         cmp2_reg <= cmp1_reg;
      end
   end

   assign cs_n_s = sync2_reg[0];
   assign ce_s   = sync2_reg[1];
   assign rc_s   = sync2_reg[2];
   assign addr_s = sync2_reg[3];
   assign w12_s  = sync2_reg[4];

   // Enable pulses shorter than one clock may be missed at this rate
   assign start = ce_s && !ce_d_reg && !cs_n_s && !rc_s
                  && (state_reg == sab_pkg::SAB_IDLE);
   assign rd_act = ce_s && !cs_n_s && rc_s;

   assign bit_cyc = bit_cycles(speed_sel);
   assign hs_cyc  = hs_cycles(speed_sel);

   // A start during a running conversion is ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= sab_pkg::SAB_IDLE;
      end else begin
         unique case (state_reg)
            sab_pkg::SAB_IDLE: begin
               if (start) begin
                  state_reg <= sab_pkg::SAB_CONV;
               end
            end
            sab_pkg::SAB_CONV: begin
               if (sif.done) begin
                  state_reg <= sab_pkg::SAB_HOLD;
               end
            end
            sab_pkg::SAB_HOLD: begin
               if (hold_reg == hs_cyc - 8'h01) begin
                  state_reg <= sab_pkg::SAB_IDLE;
               end
            end
            default: state_reg <= sab_pkg::SAB_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         short_reg <= 1'b0;
      end else if (start) begin
         short_reg <= addr_s;
      end
   end

   // Bit decision divider
   always_ff @(posedge clk) begin
      if (rst || state_reg != sab_pkg::SAB_CONV) begin
         div_reg <= 8'h00;
      end else if (div_reg == bit_cyc - 8'h01) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_reg != sab_pkg::SAB_HOLD) begin
         hold_reg <= 8'h00;
      end else begin
         hold_reg <= hold_reg + 8'h01;
      end
   end

   assign sif.start     = start;
   assign sif.short_cyc = addr_s;
   assign sif.step      = (state_reg == sab_pkg::SAB_CONV) &&
                          (div_reg == bit_cyc - 8'h01);
   assign sif.cmp_above = cmp2_reg;
   assign dac_code      = sif.trial;
   assign conversion_status = (state_reg != sab_pkg::SAB_IDLE);

   // Read layout; 8-bit mode puts both bytes on the upper eight lines
   always_comb begin
      data_next = 12'h000;
      oe_next   = `SAB_OE_NONE;
      if (rd_act) begin
         if (w12_s) begin
            data_next = sif.result;
            oe_next   = `SAB_OE_ALL;
         end else if (!addr_s) begin
            data_next = {sif.result[11:4], 4'h0};
            oe_next   = `SAB_OE_BYTE;
         end else begin
            data_next = {sif.result[3:0], 8'h00};
            oe_next   = `SAB_OE_BYTE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         result_bus_o  <= 12'h000;
         result_bus_oe <= `SAB_OE_NONE;
      end else begin
         result_bus_o  <= data_next;
         result_bus_oe <= oe_next;
      end
   end

   // Checking helpers
   logic [8:0] busy_cnt;
   int         lim_min;
   int         lim_max;

   always_ff @(posedge clk) begin
      if (rst || !conversion_status) begin
         busy_cnt <= 9'h000;
      end else begin
         busy_cnt <= busy_cnt + 9'h001;
      end
   end

   always_comb begin
      lim_min = 0;
      lim_max = 0;
      unique case ({speed_sel, short_reg})
         3'b000: begin
            lim_min = `SAB_TC12_SLOW_MIN_NS / `SAB_CLK_NS;
            lim_max = `SAB_TC12_SLOW_MAX_NS / `SAB_CLK_NS;
         end
         3'b001: begin
            lim_min = `SAB_TC8_SLOW_MIN_NS / `SAB_CLK_NS;
            lim_max = `SAB_TC8_SLOW_MAX_NS / `SAB_CLK_NS;
         end
         3'b010: begin
            lim_min = `SAB_TC12_MID_MIN_NS / `SAB_CLK_NS;
            lim_max = `SAB_TC12_MID_MAX_NS / `SAB_CLK_NS;
         end
         3'b011: begin
            lim_min = `SAB_TC8_MID_MIN_NS / `SAB_CLK_NS;
            lim_max = `SAB_TC8_MID_MAX_NS / `SAB_CLK_NS;
         end
         3'b100: lim_max = `SAB_TC12_FAST_MAX_NS / `SAB_CLK_NS;
         3'b101: lim_max = `SAB_TC8_FAST_MAX_NS / `SAB_CLK_NS;
         default: begin
            lim_min = `SAB_TC12_SLOW_MIN_NS / `SAB_CLK_NS;
            lim_max = `SAB_TC8_SLOW_MAX_NS / `SAB_CLK_NS;
         end
      endcase
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_select_gate: assert property (
      $rose(conversion_status) |->
         (!$past(cs_n_s) && $past(ce_s) && !$past(rc_s)))
      else $error("conversion began without a qualified start");

   chk_bus_release: assert property (
      (result_bus_oe != `SAB_OE_NONE) |->
         ($past(ce_s) && !$past(cs_n_s) && $past(rc_s)))
      else $error("bus driven outside a read");

   chk_status_level: assert property (
      (sif.step || $changed(dac_code)) |-> conversion_status)
      else $error("decision made while status low");

   chk_start_status: assert property (
      start |=> conversion_status && dac_code == `SAB_MSB_CODE)
      else $error("conversion did not begin at MSB");

   chk_read_width: assert property (
      $past(rd_act && w12_s) |->
         (result_bus_oe == `SAB_OE_ALL &&
          result_bus_o == $past(sif.result)))
      else $error("12-bit read layout wrong");

   chk_read_byte: assert property (
      $past(rd_act && !w12_s) |-> (result_bus_oe == `SAB_OE_BYTE))
      else $error("8-bit read enables wrong");

   chk_short_bits: assert property (
      (sif.done && short_reg) |-> (sif.result[3:0] == 4'h0))
      else $error("short cycle produced low bits");

   chk_conv_time: assert property (
      $fell(conversion_status) |->
         ($past(busy_cnt) + 1 >= lim_min &&
          $past(busy_cnt) + 1 <= lim_max))
      else $error("conversion time outside window");

   chk_status_tail: assert property (
      sif.done |-> conversion_status [*3] ##[1:9] !conversion_status)
      else $error("status fall after valid data wrong");

   chk_idle_release: assert property (
      !$past(rd_act) |-> (result_bus_oe == `SAB_OE_NONE))
      else $error("bus not released after read");

   cov_full_conv: cover property (
      sif.done && !short_reg);
   cov_short_conv: cover property (
      sif.done && short_reg);
   cov_read_low: cover property (
      rd_act && !w12_s && addr_s);
   cov_read_full: cover property (
      rd_act && w12_s ##1 result_bus_o == 12'hFFF);
endmodule
`default_nettype wire

//--- bench/sab_cmp_model.sv
// Comparator model standing in for the converter's analog die
`timescale 1ns/100ps
`default_nettype none
module sab_cmp_model (
   // Trial code and held input level
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] vin,
   // Decision back to the sequencer
   output logic             cmp_above
);
   // Ideal ladder, no offset, so each level maps to exactly one code
   assign cmp_above = (vin >= dac_code);
endmodule
`default_nettype wire

//--- bench/sab_adc_ctl_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sab_cfg.svh"
module sab_adc_ctl_tb;
   logic        clk;
   logic        rst;
   logic        cs_n;
   logic        ce;
   logic        read_conv;
   logic        byte_addr;
   logic        width_12;
   logic [1:0]  speed_sel;
   logic [11:0] vin;
   logic        cmp_above;
   logic        conversion_status;
   logic [11:0] bus_o;
   logic [11:0] bus_oe;
   logic [11:0] dac_code;
   int          error_cnt;
   int          check_count;
   int          ns;
   int          lo[6] = '{`SAB_TC12_SLOW_MIN_NS, `SAB_TC8_SLOW_MIN_NS,
                          `SAB_TC12_MID_MIN_NS, `SAB_TC8_MID_MIN_NS, 0, 0};
   int          hi[6] = '{`SAB_TC12_SLOW_MAX_NS, `SAB_TC8_SLOW_MAX_NS,
                          `SAB_TC12_MID_MAX_NS, `SAB_TC8_MID_MAX_NS,
                          `SAB_TC12_FAST_MAX_NS, `SAB_TC8_FAST_MAX_NS};
   logic [11:0] lvls[7] = '{12'h000, 12'h001, 12'h7FF, 12'h800,
                            12'hFFE, 12'hFFF, 12'h5A3};

   sab_adc_ctl DUT (
      .clk                   (clk),
      .rst                   (rst),
      .cs_n                  (cs_n),
      .ce                    (ce),
      .read_conv             (read_conv),
      .byte_addr_short_cycle (byte_addr),
      .width_12              (width_12),
      .conversion_status     (conversion_status),
      .result_bus_o          (bus_o),
      .result_bus_oe         (bus_oe),
      .speed_sel             (speed_sel),
      .cmp_above             (cmp_above),
      .dac_code              (dac_code)
   );

   sab_cmp_model cmp (
      .dac_code  (dac_code),
      .vin       (vin),
      .cmp_above (cmp_above)
   );

   always #50 clk = ~clk;

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t ns got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Enable held 300 ns, well past the 100 ns sampling blind spot
   task automatic conv(input logic sc, input logic [1:0] spd,
                       input logic [11:0] lvl, output int dur);
      int cyc;
      speed_sel = spd;
      vin = lvl;
      @(negedge clk);
      cs_n = 1'b0;
      read_conv = 1'b0;
      byte_addr = sc;
      ce = 1'b1;
      tick(3);
      ce = 1'b0;
      cyc = 3;
      while (conversion_status === 1'b1 && cyc < 1000) begin
         tick(1);
         cyc++;
      end
      cs_n = 1'b1;
      dur = cyc * `SAB_CLK_NS;
   endtask

   task automatic rd(input logic w12, input logic addr,
                     input logic [11:0] exp_oe, input logic [11:0] exp_d);
      @(negedge clk);
      cs_n = 1'b0;
      read_conv = 1'b1;
      width_12 = w12;
      byte_addr = addr;
      ce = 1'b1;
      tick(4);
      check(bus_oe, exp_oe);
      check(bus_o & exp_oe, exp_d);
      ce = 1'b0;
      tick(4);
      check(bus_oe, 12'h000);
      cs_n = 1'b1;
   endtask

   task automatic ign(input logic sel_n, input logic en, input logic rc);
      @(negedge clk);
      cs_n = sel_n;
      ce = en;
      read_conv = rc;
      tick(5);
      check(bus_oe, 12'h000);
      check({11'h000, conversion_status}, 12'h000);
      ce = 1'b0;
      cs_n = 1'b1;
      tick(3);
   endtask

   initial begin
      #1_000_000;
      error_cnt++;
      $display("[ERR] %0t ns watchdog expired", $time);
      wrap_up();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cs_n = 1'b1;
      ce = 1'b0;
      read_conv = 1'b1;
      byte_addr = 1'b0;
      width_12 = 1'b1;
      speed_sel = 2'h0;
      vin = 12'h000;
      error_cnt = 0;
      check_count = 0;
      tick(2);
      rst = 1'b0;
      tick(1);
      check(bus_oe, 12'h000);
      check(dac_code, 12'h000);
      check({11'h000, conversion_status}, 12'h000);
      $display("test reset done");
      // Every grade with both cycle lengths
      for (int i = 0; i < 6; i++) begin
         conv(i[0], 2'(i / 2), 12'h5A3, ns);
         check(12'((ns >= lo[i]) && (ns <= hi[i])), 12'h001);
         check({11'h000, conversion_status}, 12'h000);
         rd(1'b1, 1'b0, 12'hFFF, i[0] ? 12'h5A0 : 12'h5A3);
         $display("test cycle %0d done", i);
      end
      // Code boundaries on the fast grade
      for (int i = 0; i < 7; i++) begin
         conv(1'b0, 2'h2, lvls[i], ns);
         check(12'(ns <= hi[4]), 12'h001);
         rd(1'b1, 1'b0, 12'hFFF, lvls[i]);
      end
      $display("test codes done");
      rd(1'b0, 1'b0, 12'hFF0, 12'h5A0);
      rd(1'b0, 1'b1, 12'hFF0, 12'h300);
      $display("test byte reads done");
      ign(1'b1, 1'b1, 1'b0);
      ign(1'b1, 1'b1, 1'b1);
      ign(1'b0, 1'b0, 1'b1);
      ign(1'b0, 1'b0, 1'b0);
      $display("test ignored requests done");
      wrap_up();
   end
endmodule
`default_nettype wire
